// file: core/dvs_pkg.sv
// Package of constants and carrier types for the DAC volume and sequencing block.
// Assumes one 40 MHz core clock and a byte-wide plain register port.
package dvs_pkg;

   // ***************************************************************
   // Clocks and rates
   // ***************************************************************
   localparam int unsigned CLK_RATE_KHZ  = 40000;
   localparam int unsigned FS_REF_KHZ    = 48;
   localparam int unsigned MOD_OSR       = 128;
   localparam int unsigned MOD_RATE_KHZ  = MOD_OSR * FS_REF_KHZ;
   localparam logic [15:0] NCO_MODULUS   = 16'(CLK_RATE_KHZ);
   localparam logic [15:0] NCO_INCREMENT = 16'(MOD_RATE_KHZ);

   // ***************************************************************
   // Register offsets
   // ***************************************************************
   localparam logic [7:0] OFS_POWER     = 8'h00;
   localparam logic [7:0] OFS_LEFT_VOL  = 8'h01;
   localparam logic [7:0] OFS_RIGHT_VOL = 8'h02;
   localparam logic [7:0] OFS_MASTER    = 8'h03;
   localparam logic [7:0] OFS_STEP      = 8'h04;
   localparam logic [7:0] OFS_EFFECTS   = 8'h05;
   localparam logic [7:0] OFS_CM        = 8'h06;
   localparam logic [7:0] OFS_STATUS    = 8'h07;
   localparam logic [7:0] OFS_LEFT_APP  = 8'h08;
   localparam logic [7:0] OFS_RIGHT_APP = 8'h09;
   localparam logic [7:0] OFS_LEFT_SEL  = 8'h10;
   localparam logic [7:0] OFS_RIGHT_SEL = 8'h11;
   localparam logic [7:0] OFS_PGA_STEP  = 8'h12;
   localparam logic [7:0] OFS_LVL_LEFT  = 8'h20;
   localparam logic [7:0] OFS_LVL_RIGHT = 8'h28;
   localparam logic [7:0] OFS_BIAS      = 8'h6d;

   // ***************************************************************
   // Field positions and codes
   // ***************************************************************
   localparam int unsigned POWER_DAC_BIT  = 0;
   localparam int unsigned POWER_LEFT_BIT = 1;
   localparam int unsigned POWER_RIGHT_BIT = 2;
   localparam int unsigned STEP_OFF_BIT   = 0;
   localparam int unsigned STEP_HALF_BIT  = 1;
   localparam int unsigned FX_DEEMPH_BIT  = 0;
   localparam int unsigned FX_EFFECTS_BIT = 1;
   localparam int unsigned VOL_MUTE_BIT   = 7;
   localparam int unsigned BIAS_LSB       = 6;
   localparam int unsigned NUM_SOURCES    = 5;
   localparam int unsigned NUM_LEVELS     = 2 * NUM_SOURCES;
   localparam logic [7:0] VOL_MUTE_CODE   = 8'h80;
   localparam logic [3:0] LVL_MAX_CODE    = 4'h8;
   localparam logic [3:0] LVL_MUTE_CODE   = 4'h9;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [7:0] RST_VOL      = 8'h80;
   localparam logic [2:0] RST_POWER    = 3'h0;
   localparam logic [1:0] RST_STEP     = 2'h0;
   localparam logic [1:0] RST_FX       = 2'h0;
   localparam logic [1:0] RST_CM       = 2'h0;
   localparam logic [1:0] RST_BIAS     = 2'h0;
   localparam logic [7:0] RST_SEL      = 8'h00;
   localparam logic [3:0] RST_LVL      = 4'h9;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [2:0] {DVS_OFF, DVS_RUN, DVS_FX_MUTE, DVS_DOWN} dvs_state_t;

   typedef struct packed {
      logic       dac_enable;
      logic       left_analog_en;
      logic       right_analog_en;
      logic       deemph_en;
      logic       effects_en;
      logic [1:0] bias_level;
      logic [1:0] cm_level;
   } dvs_dac_cfg_t;

   typedef struct packed {
      logic [2:0] single_ended;
      logic [4:0] source_en;
   } dvs_rec_cfg_t;

endpackage : dvs_pkg

// file: core/dvs_top.sv
// DAC digital volume, soft-step, power and effect sequencing, plus record input mixing control.
// Assumes a host on the plain register port and one-cycle sample ticks from same-clock logic.
`timescale 1ns/10ps
`default_nettype none

module dvs_top
   import dvs_pkg::*;
(
   input  wire logic                          core_clk,
   input  wire logic                          rst_n,
   input  wire logic [7:0]                    reg_addr,
   input  wire logic [7:0]                    reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [7:0]                    reg_rdata,
   input  wire logic                          dac_sample_tick,
   input  wire logic                          adc_sample_tick,
   output logic                               mod_clk_en,
   output dvs_pkg::dvs_dac_cfg_t              dac_cfg,
   output logic      [7:0]                    dac_atten_left,
   output logic      [7:0]                    dac_atten_right,
   output logic                               dac_volume_done,
   output logic                               dac_powered_down,
   output dvs_pkg::dvs_rec_cfg_t [1:0]        rec_cfg,
   output logic      [dvs_pkg::NUM_LEVELS-1:0][3:0] rec_level
);
   import dvs_pkg::*;

   // ***************************************************************
   // Reset release
   // ***************************************************************
   logic [1:0] rst_sync_reg;
   wire        rst_sync_n = rst_sync_reg[1];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   // ***************************************************************
   // Register storage
   // ***************************************************************
   logic [1:0][7:0]           vol_reg;
   logic [2:0]                power_reg;
   logic [1:0]                step_reg;
   logic [1:0]                fx_reg;
   logic [1:0]                cm_reg;
   logic [1:0]                bias_reg;
   logic [1:0]                pga_step_reg;
   logic [1:0][7:0]           sel_reg;
   logic [NUM_LEVELS-1:0][3:0] lvl_reg;
   logic [7:0]                rdata_reg;

   // Write decode
   wire wr_left   = reg_wr && (reg_addr == OFS_LEFT_VOL);
   wire wr_right  = reg_wr && (reg_addr == OFS_RIGHT_VOL);
   wire wr_master = reg_wr && (reg_addr == OFS_MASTER);
   wire wr_power  = reg_wr && (reg_addr == OFS_POWER);
   wire wr_step   = reg_wr && (reg_addr == OFS_STEP);
   wire wr_fx     = reg_wr && (reg_addr == OFS_EFFECTS);
   wire wr_cm     = reg_wr && (reg_addr == OFS_CM);
   wire wr_bias   = reg_wr && (reg_addr == OFS_BIAS);
   wire wr_pga    = reg_wr && (reg_addr == OFS_PGA_STEP);
   wire wr_lsel   = reg_wr && (reg_addr == OFS_LEFT_SEL);
   wire wr_rsel   = reg_wr && (reg_addr == OFS_RIGHT_SEL);

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         vol_reg      <= {RST_VOL, RST_VOL};
         power_reg    <= RST_POWER;
         step_reg     <= RST_STEP;
         fx_reg       <= RST_FX;
         cm_reg       <= RST_CM;
         bias_reg     <= RST_BIAS;
         pga_step_reg <= RST_STEP;
         sel_reg      <= {RST_SEL, RST_SEL};
      end else begin
         if (wr_left || wr_master) begin
            vol_reg[0] <= reg_wdata;
         end
         if (wr_right || wr_master) begin
            vol_reg[1] <= reg_wdata;
         end
         if (wr_power) begin
            power_reg <= reg_wdata[2:0];
         end
         if (wr_step) begin
            step_reg <= reg_wdata[1:0];
         end
         if (wr_fx) begin
            fx_reg <= reg_wdata[1:0];
         end
         if (wr_cm) begin
            cm_reg <= reg_wdata[1:0];
         end
         if (wr_bias) begin
            bias_reg <= reg_wdata[BIAS_LSB+1:BIAS_LSB];
         end
         if (wr_pga) begin
            pga_step_reg <= reg_wdata[1:0];
         end
         if (wr_lsel) begin
            sel_reg[0] <= reg_wdata;
         end
         if (wr_rsel) begin
            sel_reg[1] <= reg_wdata;
         end
      end
   end

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   dvs_state_t state_reg;
   logic       dac_on_reg;
   logic [1:0] fx_applied_reg;
   logic       pd_flag_reg;
   logic [1:0][7:0] appl_reg;
   logic [1:0][7:0] appl_next;
   logic [1:0][7:0] target;

   wire both_muted  = (appl_reg[0] == VOL_MUTE_CODE) && (appl_reg[1] == VOL_MUTE_CODE);
   wire fx_changed  = (fx_reg != fx_applied_reg);
   wire force_mute  = (state_reg == DVS_FX_MUTE) || (state_reg == DVS_DOWN);

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_reg      <= DVS_OFF;
         dac_on_reg     <= 1'b0;
         fx_applied_reg <= RST_FX;
         pd_flag_reg    <= 1'b1;
      end else begin
         case (state_reg)
            DVS_OFF: begin
               // Output is held muted while off, so effect changes pass at once
               fx_applied_reg <= fx_reg;
               if (power_reg[POWER_DAC_BIT]) begin
                  dac_on_reg     <= 1'b1;
                  pd_flag_reg    <= 1'b0;
                  state_reg      <= DVS_RUN;
               end
            end
            DVS_RUN: begin
               if (!power_reg[POWER_DAC_BIT]) begin
                  state_reg <= DVS_DOWN;
               end else if (fx_changed) begin
                  state_reg <= DVS_FX_MUTE;
               end
            end
            DVS_FX_MUTE: begin
               if (both_muted) begin
                  fx_applied_reg <= fx_reg;
                  // Hold one cycle so the registered effect switch lands before the ramp up
                  if (!fx_changed) begin
                     state_reg <= DVS_RUN;
                  end
               end
            end
            DVS_DOWN: begin
               if (both_muted) begin
                  dac_on_reg  <= 1'b0;
                  pd_flag_reg <= 1'b1;
                  state_reg   <= DVS_OFF;
               end
            end
            default: begin
               state_reg <= DVS_OFF;
            end
         endcase
      end
   end

   // ***************************************************************
   // DAC volume soft-step
   // ***************************************************************
   logic dac_phase_reg;
   wire  dac_step_en = dac_sample_tick && (!step_reg[STEP_HALF_BIT] || dac_phase_reg);

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         dac_phase_reg <= 1'b0;
      end else if (dac_sample_tick) begin
         dac_phase_reg <= !dac_phase_reg;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         // Code n means n half-decibel steps down; the mute code sits one past the last level
         assign target[ch] = (force_mute || vol_reg[ch][VOL_MUTE_BIT]) ? VOL_MUTE_CODE :
                             {1'b0, vol_reg[ch][6:0]};

         always_comb begin
            appl_next[ch] = appl_reg[ch];
            if (!dac_on_reg) begin
               appl_next[ch] = VOL_MUTE_CODE;
            end else if (step_reg[STEP_OFF_BIT]) begin
               appl_next[ch] = target[ch];
            end else if (dac_step_en && (appl_reg[ch] < target[ch])) begin
               appl_next[ch] = appl_reg[ch] + 8'h01;
            end else if (dac_step_en && (appl_reg[ch] > target[ch])) begin
               appl_next[ch] = appl_reg[ch] - 8'h01;
            end
         end

         always_ff @(posedge core_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
               appl_reg[ch] <= VOL_MUTE_CODE;
            end else begin
               appl_reg[ch] <= appl_next[ch];
            end
         end
      end
   endgenerate

   wire vol_done = (appl_reg[0] == target[0]) && (appl_reg[1] == target[1]) && !force_mute;

   // ***************************************************************
   // Record input level soft-step
   // ***************************************************************
   // Level steps follow the record amplifier step settings, not the DAC ones
   logic adc_phase_reg;
   wire  adc_step_en = adc_sample_tick && (!pga_step_reg[STEP_HALF_BIT] || adc_phase_reg);
   logic [NUM_LEVELS-1:0][3:0] lvl_appl_reg;
   logic [NUM_LEVELS-1:0][3:0] lvl_next;
   logic [NUM_LEVELS-1:0][3:0] lvl_target;
   logic [NUM_LEVELS-1:0]      lvl_hit;

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         adc_phase_reg <= 1'b0;
      end else if (adc_sample_tick) begin
         adc_phase_reg <= !adc_phase_reg;
      end
   end

   genvar li;
   generate
      for (li = 0; li < NUM_LEVELS; li++) begin : g_level
         localparam logic [7:0] LVL_OFS = (li < NUM_SOURCES) ? OFS_LVL_LEFT + 8'(li) :
                                          OFS_LVL_RIGHT + 8'(li - NUM_SOURCES);
         assign lvl_hit[li] = (reg_addr == LVL_OFS);
         // Codes above the last level all mean mute, so a stray code never leaves a source live
         assign lvl_target[li] = (lvl_reg[li] > LVL_MAX_CODE) ? LVL_MUTE_CODE : lvl_reg[li];

         always_comb begin
            lvl_next[li] = lvl_appl_reg[li];
            if (pga_step_reg[STEP_OFF_BIT]) begin
               lvl_next[li] = lvl_target[li];
            end else if (adc_step_en && (lvl_appl_reg[li] < lvl_target[li])) begin
               lvl_next[li] = lvl_appl_reg[li] + 4'h1;
            end else if (adc_step_en && (lvl_appl_reg[li] > lvl_target[li])) begin
               lvl_next[li] = lvl_appl_reg[li] - 4'h1;
            end
         end

         always_ff @(posedge core_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
               lvl_reg[li]      <= RST_LVL;
               lvl_appl_reg[li] <= RST_LVL;
            end else begin
               if (reg_wr && lvl_hit[li]) begin
                  lvl_reg[li] <= reg_wdata[3:0];
               end
               lvl_appl_reg[li] <= lvl_next[li];
            end
         end
      end
   endgenerate

   // ***************************************************************
   // Read path
   // ***************************************************************
   logic [7:0] rd_mux;
   wire  [7:0] status_word = {5'h00, dac_on_reg, pd_flag_reg, vol_done};

   always_comb begin
      rd_mux = 8'h00;
      if (reg_addr == OFS_POWER) begin
         rd_mux = {5'h00, power_reg};
      end else if (reg_addr == OFS_LEFT_VOL) begin
         rd_mux = vol_reg[0];
      end else if (reg_addr == OFS_RIGHT_VOL) begin
         rd_mux = vol_reg[1];
      end else if (reg_addr == OFS_STEP) begin
         rd_mux = {6'h00, step_reg};
      end else if (reg_addr == OFS_EFFECTS) begin
         rd_mux = {6'h00, fx_reg};
      end else if (reg_addr == OFS_CM) begin
         rd_mux = {6'h00, cm_reg};
      end else if (reg_addr == OFS_STATUS) begin
         rd_mux = status_word;
      end else if (reg_addr == OFS_LEFT_APP) begin
         rd_mux = appl_reg[0];
      end else if (reg_addr == OFS_RIGHT_APP) begin
         rd_mux = appl_reg[1];
      end else if (reg_addr == OFS_LEFT_SEL) begin
         rd_mux = sel_reg[0];
      end else if (reg_addr == OFS_RIGHT_SEL) begin
         rd_mux = sel_reg[1];
      end else if (reg_addr == OFS_PGA_STEP) begin
         rd_mux = {6'h00, pga_step_reg};
      end else if (reg_addr == OFS_BIAS) begin
         rd_mux = {bias_reg, 6'h00};
      end else begin
         for (int i = 0; i < NUM_LEVELS; i++) begin
            if (lvl_hit[i]) begin
               rd_mux = {4'h0, lvl_reg[i]};
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // ***************************************************************
   // Modulator rate enable
   // ***************************************************************
   // Fractional divider: the core clock is no integer multiple of 128 fs, so edges jitter by one cycle
   logic [15:0] nco_reg;
   logic        mod_en_reg;
   wire  [15:0] nco_sum  = nco_reg + NCO_INCREMENT;
   wire         nco_wrap = (nco_sum >= NCO_MODULUS);

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         nco_reg    <= 16'h0000;
         mod_en_reg <= 1'b0;
      end else begin
         nco_reg    <= nco_wrap ? nco_sum - NCO_MODULUS : nco_sum;
         mod_en_reg <= nco_wrap && dac_on_reg;
      end
   end

   // ***************************************************************
   // Registered outputs
   // ***************************************************************
   dvs_dac_cfg_t            cfg_reg;
   dvs_rec_cfg_t [1:0]      rec_reg;
   logic                    done_reg;

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cfg_reg  <= '0;
         rec_reg  <= '0;
         done_reg <= 1'b0;
      end else begin
         cfg_reg.dac_enable      <= dac_on_reg;
         cfg_reg.left_analog_en  <= dac_on_reg && power_reg[POWER_LEFT_BIT];
         cfg_reg.right_analog_en <= dac_on_reg && power_reg[POWER_RIGHT_BIT];
         cfg_reg.deemph_en       <= fx_applied_reg[FX_DEEMPH_BIT];
         cfg_reg.effects_en      <= fx_applied_reg[FX_EFFECTS_BIT];
         cfg_reg.bias_level      <= bias_reg;
         cfg_reg.cm_level        <= cm_reg;
         // Source 0 own line 1, 1 own line 2, 2 opposite line 1, 3 left mic 3, 4 right mic 3
         rec_reg[0] <= sel_reg[0];
         rec_reg[1] <= sel_reg[1];
         done_reg   <= vol_done;
      end
   end

   assign reg_rdata        = rdata_reg;
   assign mod_clk_en       = mod_en_reg;
   assign dac_cfg          = cfg_reg;
   assign dac_atten_left   = appl_reg[0];
   assign dac_atten_right  = appl_reg[1];
   assign dac_volume_done  = done_reg;
   assign dac_powered_down = pd_flag_reg;
   assign rec_cfg          = rec_reg;
   assign rec_level        = lvl_appl_reg;

endmodule : dvs_top

`default_nettype wire

// file: test/dvs_host_pace.sv
// Host-side sample pacing model: DAC and record sample ticks.
// Assumes the core clock; ticks are sent only while run is high.
`timescale 1ns/10ps
`default_nettype none
module dvs_host_pace #(
   parameter int unsigned PERIOD = 8
) (
   input  wire logic core_clk,
   input  wire logic run,
   output var  logic dac_tick,
   output var  logic adc_tick
);
   // ******
   // Tick pacing
   // ******
   int unsigned cnt = 0;
   initial begin
      dac_tick = 1'b0;
      adc_tick = 1'b0;
   end
   // Restart on run so a count of ticks always begins one full period later
   always @(posedge core_clk) begin
      cnt      <= (run && cnt < PERIOD - 1) ? cnt + 1 : 0;
      dac_tick <= run && cnt == PERIOD - 1;
      adc_tick <= run && cnt == PERIOD - 1;
   end
endmodule : dvs_host_pace
`default_nettype wire

// file: test/dvs_chk_assertions.sv
// Checker for volume, sequencing and record selection outputs.
// Assumes binding to dvs_top and the offsets of dvs_pkg.
`timescale 1ns/10ps
`default_nettype none
module dvs_chk
   import dvs_pkg::*;
(
   input wire logic                        core_clk,
   input wire logic                        rst_n,
   input wire logic [7:0]                  reg_addr,
   input wire logic [7:0]                  reg_wdata,
   input wire logic                        reg_wr,
   input wire logic                        dac_sample_tick,
   input wire logic                        mod_clk_en,
   input wire dvs_pkg::dvs_dac_cfg_t       dac_cfg,
   input wire logic [7:0]                  dac_atten_left,
   input wire logic [7:0]                  dac_atten_right,
   input wire logic                        dac_volume_done,
   input wire logic                        dac_powered_down,
   input wire dvs_pkg::dvs_rec_cfg_t [1:0] rec_cfg
);
   // ******
   // Shadow of step mode and targets
   // ******
   logic       step_off_reg;
   logic [7:0] tgt_l_reg;
   logic [7:0] tgt_r_reg;
   logic [1:0] age_reg;
   wire        wr_l = reg_wr && (reg_addr == OFS_LEFT_VOL || reg_addr == OFS_MASTER);
   wire        wr_r = reg_wr && (reg_addr == OFS_RIGHT_VOL || reg_addr == OFS_MASTER);
   wire        wr_s = reg_wr && reg_addr == OFS_STEP;
   wire [7:0]  wr_v = reg_wdata[VOL_MUTE_BIT] ? VOL_MUTE_CODE : reg_wdata;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         step_off_reg <= 1'b0;
         tgt_l_reg    <= RST_VOL;
         tgt_r_reg    <= RST_VOL;
         age_reg      <= 2'h0;
      end else begin
         step_off_reg <= wr_s ? reg_wdata[STEP_OFF_BIT] : step_off_reg;
         tgt_l_reg    <= wr_l ? wr_v : tgt_l_reg;
         tgt_r_reg    <= wr_r ? wr_v : tgt_r_reg;
         age_reg      <= (wr_l || wr_r || wr_s) ? 2'h0 : age_reg + {1'b0, age_reg != 2'h3};
      end
   end
   // ******
   // Properties
   // ******
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_quiet;
      !mod_clk_en [*5];
   endsequence
   // A step mode change may jump once, so stepping is judged two cycles later
   sequence s_stepping;
      !step_off_reg && !$past(step_off_reg) && !$past(step_off_reg, 2);
   endsequence
   a_step_left: assert property (s_stepping ##0 $changed(dac_atten_left) |->
      (dac_atten_left - $past(dac_atten_left) == 8'h01 || $past(dac_atten_left) - dac_atten_left == 8'h01))
      else $error("left attenuation moved by more than one code");
   a_step_tick: assert property (s_stepping ##0 $changed(dac_atten_right) |->
      $past(dac_sample_tick) || $past(dac_sample_tick, 2)) else $error("right attenuation moved without a sample");
   a_done_target: assert property (dac_volume_done && age_reg == 2'h3 && dac_cfg.dac_enable
      && $past(dac_cfg.dac_enable, 3) |-> dac_atten_left == tgt_l_reg && dac_atten_right == tgt_r_reg)
      else $error("done flag set away from target");
   a_power_muted: assert property ($changed(dac_powered_down) |->
      dac_atten_left == VOL_MUTE_CODE && dac_atten_right == VOL_MUTE_CODE) else $error("power edge while not muted");
   a_fx_muted: assert property ($changed({dac_cfg.deemph_en, dac_cfg.effects_en}) |->
      dac_atten_left == VOL_MUTE_CODE && dac_atten_right == VOL_MUTE_CODE) else $error("effects switched unmuted");
   a_bias_write: assert property (reg_wr && reg_addr == OFS_BIAS |=> ##1
      {dac_cfg.bias_level, 6'h00} == ($past(reg_wdata, 2) & 8'hc0)) else $error("bias level not taken");
   a_sel_copy: assert property (reg_wr && reg_addr == OFS_LEFT_SEL |=> ##1
      rec_cfg[0] == $past(reg_wdata, 2)) else $error("left selection not taken");
   a_modclk_gap: assert property (mod_clk_en |=> s_quiet) else $error("modulator pulses too close");
   a_modclk_next: assert property (mod_clk_en && dac_cfg.dac_enable |->
      ##[6:7] (mod_clk_en || !dac_cfg.dac_enable)) else $error("modulator pulse late");
endmodule : dvs_chk
bind dvs_top dvs_chk u_chk (
   .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .dac_sample_tick, .mod_clk_en, .dac_cfg,
   .dac_atten_left, .dac_atten_right, .dac_volume_done, .dac_powered_down, .rec_cfg
);
`default_nettype wire

// file: test/test_dac_volume_softstep_control.sv
// Self-checking bench for the volume, sequencing and record selection block.
// Assumes the pacing model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module test_dac_volume_softstep_control;
   import dvs_pkg::*;
   // ******
   // Stimulus and observation
   // ******
   logic                       core_clk  = 1'b0;
   logic                       rst_n     = 1'b0;
   logic [7:0]                 reg_addr  = 8'h00;
   logic [7:0]                 reg_wdata = 8'h00;
   logic                       reg_wr    = 1'b0;
   logic                       reg_rd    = 1'b0;
   logic                       pace_on   = 1'b0;
   logic [7:0]                 reg_rdata, dac_atten_left, dac_atten_right, snap;
   logic                       dac_sample_tick, adc_sample_tick, mod_clk_en, dac_volume_done, dac_powered_down;
   dvs_dac_cfg_t               dac_cfg;
   dvs_rec_cfg_t [1:0]         rec_cfg;
   logic [NUM_LEVELS-1:0][3:0] rec_level;
   int                         error_cnt   = 0;
   int                         comparisons = 0;
   always #12.5 core_clk = ~core_clk;
   dvs_top dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dac_sample_tick,
      .adc_sample_tick, .mod_clk_en, .dac_cfg, .dac_atten_left, .dac_atten_right, .dac_volume_done,
      .dac_powered_down, .rec_cfg, .rec_level);
   dvs_host_pace u_pace (.core_clk, .run(pace_on), .dac_tick(dac_sample_tick), .adc_tick(adc_sample_tick));
   // ******
   // Tasks
   // ******
   task automatic conclude;
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask : rd
   task automatic settle;
      repeat (3) @(posedge core_clk);
      #1;
   endtask : settle
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge core_clk);
         while (dac_sample_tick !== 1'b1) @(posedge core_clk);
      end
      settle;
   endtask : ticks
   // Snapshot is taken at the edge that shows the flag, before later steps land
   task automatic wait_for(input bit pick);
      for (int i = 0; i < 2000; i++) begin
         @(posedge core_clk);
         snap = dac_atten_left;
         if ((pick ? dac_powered_down : dac_cfg.deemph_en) === 1'b1) break;
      end
   endtask : wait_for
   // ******
   // Sequence of tests
   // ******
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      conclude;
   end
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(OFS_STATUS, 8'h03);
      rd(OFS_LEFT_APP, VOL_MUTE_CODE);
      rd(OFS_BIAS, 8'h00);
      rd(8'h3f, 8'h00);
      check({4'h0, rec_level[5]}, 8'h09);
      wr(OFS_BIAS, 8'hc0);
      wr(OFS_CM, 8'h03);
      rd(OFS_BIAS, 8'hc0);
      check({6'h00, dac_cfg.cm_level}, 8'h03);
      wr(OFS_LEFT_VOL, 8'h7c);
      wr(OFS_RIGHT_VOL, 8'h7e);
      wr(OFS_POWER, 8'h07);
      settle;
      check({5'h00, dac_cfg.dac_enable, dac_cfg.left_analog_en, dac_cfg.right_analog_en}, 8'h07);
      pace_on <= 1'b1;
      ticks(2);
      check(dac_atten_right, 8'h7e);
      rd(OFS_STATUS, 8'h04);
      ticks(2);
      check(dac_atten_left, 8'h7c);
      rd(OFS_STATUS, 8'h05);
      check({7'h00, dac_volume_done}, 8'h01);
      pace_on <= 1'b0;
      wr(OFS_STEP, 8'h02);
      wr(OFS_LEFT_VOL, 8'h70);
      pace_on <= 1'b1;
      ticks(8);
      check(dac_atten_left, 8'h78);
      pace_on <= 1'b0;
      wr(OFS_STEP, 8'h01);
      wr(OFS_MASTER, 8'h7c);
      settle;
      check(dac_atten_left, 8'h7c);
      check(dac_atten_right, 8'h7c);
      rd(OFS_MASTER, 8'h00);
      wr(OFS_STEP, 8'h00);
      wr(OFS_EFFECTS, 8'h01);
      pace_on <= 1'b1;
      ticks(2);
      check({dac_atten_left[6:0], dac_cfg.deemph_en}, 8'hfc);
      wait_for(1'b0);
      check(snap, VOL_MUTE_CODE);
      ticks(6);
      check(dac_atten_left, 8'h7c);
      pace_on <= 1'b0;
      wr(OFS_POWER, 8'h00);
      pace_on <= 1'b1;
      ticks(2);
      check({dac_atten_left[6:0], dac_powered_down}, 8'hfc);
      wait_for(1'b1);
      check(snap, VOL_MUTE_CODE);
      pace_on <= 1'b0;
      wr(OFS_LEFT_SEL, 8'he5);
      wr(OFS_RIGHT_SEL, 8'h8c);
      wr(OFS_PGA_STEP, 8'h01);
      wr(OFS_LVL_LEFT, 8'h03);
      settle;
      check(rec_cfg[0], 8'he5);
      check(rec_cfg[1], 8'h8c);
      check({4'h0, rec_level[0]}, 8'h03);
      check({7'h00, dac_cfg.dac_enable}, 8'h00);
      wr(OFS_PGA_STEP, 8'h00);
      wr(OFS_LVL_RIGHT + 8'h04, 8'h00);
      wr(OFS_LVL_LEFT, 8'h0c);
      pace_on <= 1'b1;
      ticks(2);
      check({4'h0, rec_level[9]}, 8'h07);
      ticks(6);
      check({4'h0, rec_level[0]}, LVL_MUTE_CODE);
      conclude;
   end
endmodule : test_dac_volume_softstep_control
`default_nettype wire
